// >>> hcam_monitor.sv
// hcam_monitor: change-rate alarm, heater burnout/short/overcurrent alarms, alarm output one
// assumes process value, sensor currents and heating output come from logic on sys_clk
`default_nettype none
`timescale 1ns/1ps

// Operation
// - each period end, alarm when current minus previous process value exceeds value
// - calculation period counted in whole 250 ms sampling ticks
// - positive value detects rise, negative value detects fall
// - period accepts 1 to 999 ticks, defaults to 4
// - burnout and overcurrent judged while heating on, short while off
// - no heater alarms when the output is assigned to cooling
// - burnout off while current above threshold, on when below
// - short off while leakage below threshold, on when above
// - overcurrent off while current below threshold, on when above
// - on-interval of 100 ms or less skips burnout and overcurrent
// - off-interval of 100 ms or less skips the short check
// - alarm output one is alarm function OR all heater alarms
// - heater alarms never stop the control output
// - no current at power-up with heater powered later gives burnout
// - thresholds 0.1 to 49.9 A detect normally
// - threshold 0.0 forces burnout off, short on, overcurrent on
// - threshold 50.0 forces burnout on, short off, overcurrent off
// - monitors read FFFF above 55.0 A
// - heater and leakage monitors readable for both channels
// - alarm-one type defaults to code 2, upper limit
// - type 2 alarms when process value exceeds set point by alarm value
module hcam_monitor #(
	parameter int SAMPLE_CYCLES = hcam_pkg::SAMPLE_CYCLES,
	parameter int SKIP_CYCLES = hcam_pkg::SKIP_CYCLES,
	parameter int NCH = 2
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] processValue,
	input wire logic heatingOutput,
	input wire logic currentValid,
	input wire logic [NCH-1:0][15:0] currentSensorInput,
	output logic [NCH-1:0] burnoutAlarm,
	output logic [NCH-1:0] shortAlarm,
	output logic [NCH-1:0] overcurrentAlarm,
	output logic rateAlarm,
	output logic alarmOutputOne
);

	// merge a bus write into a register under its byte strobes
	function automatic logic [31:0] hcamMerge(input logic [31:0] oldVal, input logic [31:0] newVal,
		input logic [3:0] strb);
		logic [31:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = newVal[8*b +: 8];
			end
		end
		return res;
	endfunction

	// bus handshake state
	logic [7:0] awAddr_reg;
	logic awHeld_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic wHeld_reg;
	logic wrEn;

	// software-visible settings
	logic latchEn_reg;
	logic coolAssign_reg;
	logic rateClear;
	logic [3:0] alarmType_reg;
	logic [15:0] alarmValue_reg;
	logic [15:0] setPoint_reg;
	logic [9:0] ratePeriod_reg;
	logic [15:0] rateValue_reg;
	logic [15:0] burnoutThr_reg [NCH];
	logic [15:0] shortThr_reg [NCH];
	logic [15:0] overcurThr_reg [NCH];
	logic [15:0] heatMon_reg [NCH];
	logic [15:0] leakMon_reg [NCH];

	// sampling and interval timing
	logic [31:0] tickCnt_reg;
	logic sampleTick;
	logic [9:0] periodCnt_reg;
	logic [15:0] pvPrev_reg;
	logic pvPrevValid_reg;
	logic heatPrev_reg;
	logic [31:0] intervalCnt_reg;
	logic intervalLong;
	logic onEnd;
	logic offEnd;
	logic upperHit_reg;
	logic alarmFunc;

	assign wrEn = awHeld_reg && wHeld_reg && !s_axi_bvalid;

	// write address channel; ready drops while an address waits so the payload is held here
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_reg <= 1'b1;
			awAddr_reg <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			awHeld_reg <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel, taken independently of the address
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wHeld_reg <= 1'b0;
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_reg <= 1'b1;
			wData_reg <= s_axi_wdata;
			wStrb_reg <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			wHeld_reg <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// write response once both halves are in
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= hcam_pkg::RESP_OKAY;
		end else if (wrEn) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awAddr_reg <= hcam_pkg::OFF_OVERCUR_THR1 && awAddr_reg[1:0] == 2'h0) ?
				hcam_pkg::RESP_OKAY : hcam_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register writes; the period is clamped into its legal range
	always_ff @(posedge sys_clk or negedge nrst) begin
		logic [31:0] m;
		m = 32'h00000000;
		if (!nrst) begin
			latchEn_reg <= 1'b0;
			coolAssign_reg <= 1'b0;
			alarmType_reg <= hcam_pkg::ALM_TYPE_RESET;
			alarmValue_reg <= hcam_pkg::ALARM_OUTPUT_ONE_VALUE_RESET;
			setPoint_reg <= hcam_pkg::SET_POINT_RESET;
			ratePeriod_reg <= hcam_pkg::PERIOD_RESET;
			rateValue_reg <= hcam_pkg::RATE_VALUE_RESET;
			for (int c = 0; c < NCH; c++) begin
				burnoutThr_reg[c] <= hcam_pkg::BURNOUT_THR_RESET;
				shortThr_reg[c] <= hcam_pkg::SHORT_THR_RESET;
				overcurThr_reg[c] <= hcam_pkg::OVERCUR_THR_RESET;
			end
		end else if (wrEn) begin
			unique case (awAddr_reg)
				hcam_pkg::OFF_CTRL: begin
					m = hcamMerge({30'h0, coolAssign_reg, latchEn_reg}, wData_reg, wStrb_reg);
					latchEn_reg <= m[hcam_pkg::CTRL_LATCH_BIT];
					coolAssign_reg <= m[hcam_pkg::CTRL_COOL_BIT];
				end
				hcam_pkg::OFF_ALARM_OUTPUT_ONE_TYPE: begin
					m = hcamMerge({28'h0, alarmType_reg}, wData_reg, wStrb_reg);
					alarmType_reg <= m[3:0];
				end
				hcam_pkg::OFF_ALARM_OUTPUT_ONE_VALUE: begin
					m = hcamMerge({16'h0, alarmValue_reg}, wData_reg, wStrb_reg);
					alarmValue_reg <= m[15:0];
				end
				hcam_pkg::OFF_SET_POINT: begin
					m = hcamMerge({16'h0, setPoint_reg}, wData_reg, wStrb_reg);
					setPoint_reg <= m[15:0];
				end
				hcam_pkg::OFF_RATE_PERIOD: begin
					m = hcamMerge({22'h0, ratePeriod_reg}, wData_reg, wStrb_reg);
					if (m[15:0] < {6'h0, hcam_pkg::PERIOD_MIN}) begin
						ratePeriod_reg <= hcam_pkg::PERIOD_MIN;
					end else if (m[15:0] > {6'h0, hcam_pkg::PERIOD_MAX}) begin
						ratePeriod_reg <= hcam_pkg::PERIOD_MAX;
					end else begin
						ratePeriod_reg <= m[9:0];
					end
				end
				hcam_pkg::OFF_RATE_VALUE: begin
					m = hcamMerge({16'h0, rateValue_reg}, wData_reg, wStrb_reg);
					rateValue_reg <= m[15:0];
				end
				default: begin
					// threshold block: index from the offset, 50.0 A is the top code
					for (int c = 0; c < NCH; c++) begin
						if (awAddr_reg == hcam_pkg::OFF_BURNOUT_THR0 + 8'(4 * c)) begin
							m = hcamMerge({16'h0, burnoutThr_reg[c]}, wData_reg, wStrb_reg);
							burnoutThr_reg[c] <= (m[15:0] > hcam_pkg::THR_MAX) ? hcam_pkg::THR_MAX : m[15:0];
						end
						if (awAddr_reg == hcam_pkg::OFF_SHORT_THR0 + 8'(4 * c)) begin
							m = hcamMerge({16'h0, shortThr_reg[c]}, wData_reg, wStrb_reg);
							shortThr_reg[c] <= (m[15:0] > hcam_pkg::THR_MAX) ? hcam_pkg::THR_MAX : m[15:0];
						end
						if (awAddr_reg == hcam_pkg::OFF_OVERCUR_THR0 + 8'(4 * c)) begin
							m = hcamMerge({16'h0, overcurThr_reg[c]}, wData_reg, wStrb_reg);
							overcurThr_reg[c] <= (m[15:0] > hcam_pkg::THR_MAX) ? hcam_pkg::THR_MAX : m[15:0];
						end
					end
				end
			endcase
		end
	end

	// clear of a latched change-rate alarm is a pulse, never stored
	assign rateClear = wrEn && awAddr_reg == hcam_pkg::OFF_CTRL && wStrb_reg[0]
		&& wData_reg[hcam_pkg::CTRL_CLEAR_BIT];

	// read channel: one cycle from address to data
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= hcam_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= hcam_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				hcam_pkg::OFF_CTRL: s_axi_rdata <= {30'h0, coolAssign_reg, latchEn_reg};
				hcam_pkg::OFF_ALARM_OUTPUT_ONE_TYPE: s_axi_rdata <= {28'h0, alarmType_reg};
				hcam_pkg::OFF_ALARM_OUTPUT_ONE_VALUE: s_axi_rdata <= {16'h0, alarmValue_reg};
				hcam_pkg::OFF_SET_POINT: s_axi_rdata <= {16'h0, setPoint_reg};
				hcam_pkg::OFF_RATE_PERIOD: s_axi_rdata <= {22'h0, ratePeriod_reg};
				hcam_pkg::OFF_RATE_VALUE: s_axi_rdata <= {16'h0, rateValue_reg};
				hcam_pkg::OFF_BURNOUT_THR0: s_axi_rdata <= {16'h0, burnoutThr_reg[0]};
				hcam_pkg::OFF_BURNOUT_THR1: s_axi_rdata <= {16'h0, burnoutThr_reg[1]};
				hcam_pkg::OFF_SHORT_THR0: s_axi_rdata <= {16'h0, shortThr_reg[0]};
				hcam_pkg::OFF_SHORT_THR1: s_axi_rdata <= {16'h0, shortThr_reg[1]};
				hcam_pkg::OFF_OVERCUR_THR0: s_axi_rdata <= {16'h0, overcurThr_reg[0]};
				hcam_pkg::OFF_OVERCUR_THR1: s_axi_rdata <= {16'h0, overcurThr_reg[1]};
				hcam_pkg::OFF_STATUS: s_axi_rdata <= {22'h0, overcurrentAlarm, shortAlarm, burnoutAlarm, 1'b0,
					upperHit_reg, rateAlarm, alarmOutputOne};
				hcam_pkg::OFF_HEAT_MON0: s_axi_rdata <= {16'h0, heatMon_reg[0]};
				hcam_pkg::OFF_HEAT_MON1: s_axi_rdata <= {16'h0, heatMon_reg[1]};
				hcam_pkg::OFF_LEAK_MON0: s_axi_rdata <= {16'h0, leakMon_reg[0]};
				hcam_pkg::OFF_LEAK_MON1: s_axi_rdata <= {16'h0, leakMon_reg[1]};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= hcam_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// 250 ms sampling tick
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tickCnt_reg <= 32'h00000000;
		end else if (tickCnt_reg == 32'(SAMPLE_CYCLES - 1)) begin
			tickCnt_reg <= 32'h00000000;
		end else begin
			tickCnt_reg <= tickCnt_reg + 32'h00000001;
		end
	end
	assign sampleTick = tickCnt_reg == 32'(SAMPLE_CYCLES - 1);

	// period counter in sampling ticks; a shortened period applies to the period already running
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			periodCnt_reg <= 10'h000;
		end else if (sampleTick) begin
			periodCnt_reg <= (periodCnt_reg + 10'h001 >= ratePeriod_reg) ? 10'h000 : periodCnt_reg + 10'h001;
		end
	end

	// change-rate evaluation at each period end
	always_ff @(posedge sys_clk or negedge nrst) begin
		logic [16:0] diff;
		logic hit;
		diff = 17'(signed'(processValue)) - 17'(signed'(pvPrev_reg));
		hit = 1'b0;
		if (!rateValue_reg[15]) begin
			hit = rateValue_reg != 16'h0000 && signed'(diff) > signed'(17'(signed'(rateValue_reg)));
		end else begin
			hit = signed'(diff) < signed'(17'(signed'(rateValue_reg)));
		end
		if (!nrst) begin
			pvPrev_reg <= 16'h0000;
			pvPrevValid_reg <= 1'b0;
			rateAlarm <= 1'b0;
		end else begin
			if (sampleTick && periodCnt_reg + 10'h001 >= ratePeriod_reg) begin
				pvPrev_reg <= processValue;
				pvPrevValid_reg <= 1'b1;
			end
			// latched mode: a new hit wins over a clear in the same cycle
			if (sampleTick && periodCnt_reg + 10'h001 >= ratePeriod_reg && pvPrevValid_reg) begin
				rateAlarm <= latchEn_reg ? (hit || (rateAlarm && !rateClear)) : hit;
			end else if (rateClear) begin
				rateAlarm <= 1'b0;
			end
		end
	end

	// upper-limit deviation alarm, type code 2
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			upperHit_reg <= 1'b0;
		end else begin
			upperHit_reg <= signed'(17'(signed'(processValue)) - 17'(signed'(setPoint_reg)))
				> signed'(17'(signed'(alarmValue_reg)));
		end
	end

	// heating on/off interval length, saturating at the skip limit
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			heatPrev_reg <= 1'b0;
			intervalCnt_reg <= 32'h00000000;
		end else begin
			heatPrev_reg <= heatingOutput;
			if (heatingOutput != heatPrev_reg) begin
				intervalCnt_reg <= 32'h00000000;
			end else if (!intervalLong) begin
				intervalCnt_reg <= intervalCnt_reg + 32'h00000001;
			end
		end
	end
	assign intervalLong = intervalCnt_reg >= 32'(SKIP_CYCLES);
	assign onEnd = heatPrev_reg && !heatingOutput && intervalLong;
	assign offEnd = !heatPrev_reg && heatingOutput && intervalLong;

	// per-channel current capture, judgement and forced threshold codes
	for (genvar c = 0; c < NCH; c++) begin : g_chan
		logic [15:0] onCur_reg;
		logic [15:0] offCur_reg;
		logic burnEval_reg;
		logic shortEval_reg;
		logic overEval_reg;

		// latest sample in each interval; monitors show the current, FFFF above 55.0 A
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				onCur_reg <= 16'h0000;
				offCur_reg <= 16'h0000;
				heatMon_reg[c] <= 16'h0000;
				leakMon_reg[c] <= 16'h0000;
			end else if (currentValid) begin
				if (heatingOutput) begin
					onCur_reg <= currentSensorInput[c];
					heatMon_reg[c] <= (currentSensorInput[c] > hcam_pkg::OVERFLOW_LIMIT) ?
						hcam_pkg::OVERFLOW_CODE : currentSensorInput[c];
				end else begin
					offCur_reg <= currentSensorInput[c];
					leakMon_reg[c] <= (currentSensorInput[c] > hcam_pkg::OVERFLOW_LIMIT) ?
						hcam_pkg::OVERFLOW_CODE : currentSensorInput[c];
				end
			end
		end

		// judged once per long interval, held otherwise; no current at power-up reads as burnout
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				burnEval_reg <= 1'b0;
				shortEval_reg <= 1'b0;
				overEval_reg <= 1'b0;
			end else begin
				if (onEnd) begin
					burnEval_reg <= onCur_reg < burnoutThr_reg[c];
					overEval_reg <= onCur_reg > overcurThr_reg[c];
				end
				if (offEnd) begin
					shortEval_reg <= offCur_reg > shortThr_reg[c];
				end
			end
		end

		// end codes override detection; cooling assignment silences all three heater alarms
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				burnoutAlarm[c] <= 1'b0;
				shortAlarm[c] <= 1'b0;
				overcurrentAlarm[c] <= 1'b0;
			end else if (coolAssign_reg) begin
				burnoutAlarm[c] <= 1'b0;
				shortAlarm[c] <= 1'b0;
				overcurrentAlarm[c] <= 1'b0;
			end else begin
				burnoutAlarm[c] <= (burnoutThr_reg[c] == hcam_pkg::THR_OFF) ? 1'b0 :
					(burnoutThr_reg[c] == hcam_pkg::THR_MAX) ? 1'b1 : burnEval_reg;
				shortAlarm[c] <= (shortThr_reg[c] == hcam_pkg::THR_OFF) ? 1'b1 :
					(shortThr_reg[c] == hcam_pkg::THR_MAX) ? 1'b0 : shortEval_reg;
				overcurrentAlarm[c] <= (overcurThr_reg[c] == hcam_pkg::THR_OFF) ? 1'b1 :
					(overcurThr_reg[c] == hcam_pkg::THR_MAX) ? 1'b0 : overEval_reg;
			end
		end
	end

	// alarm function by type; codes without logic here read as off
	always_comb begin
		alarmFunc = 1'b0;
		if (alarmType_reg == hcam_pkg::ALM_TYPE_UPPER) begin
			alarmFunc = upperHit_reg;
		end else if (alarmType_reg == hcam_pkg::ALM_TYPE_RATE) begin
			alarmFunc = rateAlarm;
		end
	end

	// heater alarms only report; heatingOutput is never gated here
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			alarmOutputOne <= 1'b0;
		end else begin
			alarmOutputOne <= alarmFunc || (|burnoutAlarm) || (|shortAlarm) || (|overcurrentAlarm);
		end
	end

endmodule // hcam_monitor

`default_nettype wire

// >>> hcam_pkg.sv
// hcam_pkg: constants for the heater current alarm monitor
// assumes a 125 MHz system clock and currents coded in 0.1 A steps
`default_nettype none

package hcam_pkg;

	// clock rate and time figures
	localparam int CLK_HZ = 125_000_000;
	localparam int SAMPLE_MS = 250;
	localparam int SKIP_MS = 100;
	localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
	localparam int SKIP_CYCLES = CLK_HZ / 1000 * SKIP_MS;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ALARM_OUTPUT_ONE_TYPE = 8'h04;
	localparam logic [7:0] OFF_ALARM_OUTPUT_ONE_VALUE = 8'h08;
	localparam logic [7:0] OFF_SET_POINT = 8'h0c;
	localparam logic [7:0] OFF_RATE_PERIOD = 8'h10;
	localparam logic [7:0] OFF_RATE_VALUE = 8'h14;
	localparam logic [7:0] OFF_BURNOUT_THR0 = 8'h18;
	localparam logic [7:0] OFF_BURNOUT_THR1 = 8'h1c;
	localparam logic [7:0] OFF_SHORT_THR0 = 8'h20;
	localparam logic [7:0] OFF_SHORT_THR1 = 8'h24;
	localparam logic [7:0] OFF_OVERCUR_THR0 = 8'h28;
	localparam logic [7:0] OFF_OVERCUR_THR1 = 8'h2c;
	localparam logic [7:0] OFF_STATUS = 8'h30;
	localparam logic [7:0] OFF_HEAT_MON0 = 8'h34;
	localparam logic [7:0] OFF_HEAT_MON1 = 8'h38;
	localparam logic [7:0] OFF_LEAK_MON0 = 8'h3c;
	localparam logic [7:0] OFF_LEAK_MON1 = 8'h40;

	// control register fields
	localparam int CTRL_LATCH_BIT = 0;
	localparam int CTRL_COOL_BIT = 1;
	localparam int CTRL_CLEAR_BIT = 2;

	// status register fields
	localparam int ST_ALARM_ONE_BIT = 0;
	localparam int ST_RATE_BIT = 1;
	localparam int ST_UPPER_BIT = 2;
	localparam int ST_BURNOUT_POS = 4;
	localparam int ST_SHORT_POS = 6;
	localparam int ST_OVERCUR_POS = 8;

	// alarm-one type codes and reset values
	localparam logic [3:0] ALM_TYPE_OFF = 4'h0;
	localparam logic [3:0] ALM_TYPE_UPPER = 4'h2;
	localparam logic [3:0] ALM_TYPE_RATE = 4'hd;
	localparam logic [3:0] ALM_TYPE_RESET = ALM_TYPE_UPPER;
	localparam logic [15:0] ALARM_OUTPUT_ONE_VALUE_RESET = 16'h0000;
	localparam logic [15:0] SET_POINT_RESET = 16'h0000;
	localparam logic [15:0] RATE_VALUE_RESET = 16'h0000;
	localparam logic [9:0] PERIOD_MIN = 10'h001;
	localparam logic [9:0] PERIOD_MAX = 10'h3e7;
	localparam logic [9:0] PERIOD_RESET = 10'h004;

	// thresholds and monitor codes, 0.1 A per step
	localparam logic [15:0] THR_OFF = 16'h0000;
	localparam logic [15:0] THR_MAX = 16'h01f4;
	localparam logic [15:0] BURNOUT_THR_RESET = THR_OFF;
	localparam logic [15:0] SHORT_THR_RESET = THR_MAX;
	localparam logic [15:0] OVERCUR_THR_RESET = THR_MAX;
	localparam logic [15:0] OVERFLOW_LIMIT = 16'h0226;
	localparam logic [15:0] OVERFLOW_CODE = 16'hffff;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// >>> hcam_monitor_properties.sv
// hcam_monitor_properties: bus and alarm timing checks for hcam_monitor
// assumes one sys_clk domain; bound to every hcam_monitor instance
`default_nettype none
`timescale 1ns/1ps
module hcam_monitor_props #(
	parameter int NCH = 2
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic heatingOutput,
	input wire logic [NCH-1:0] burnoutAlarm,
	input wire logic [NCH-1:0] shortAlarm,
	input wire logic [NCH-1:0] overcurrentAlarm,
	input wire logic rateAlarm,
	input wire logic alarmOutputOne
);
	logic heatPrev;
	logic [3:0] quietCnt;
	default clocking dcb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// cycles since heating toggled or a register write; heater alarms only move shortly after one
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			heatPrev <= 1'b0;
			quietCnt <= 4'h0;
		end else begin
			heatPrev <= heatingOutput;
			if (heatingOutput != heatPrev || (s_axi_wvalid && s_axi_wready))
				quietCnt <= 4'h0;
			else if (quietCnt != 4'hf)
				quietCnt <= quietCnt + 4'h1;
		end
	end
	a_aor_one: assert property ((|burnoutAlarm || |shortAlarm || |overcurrentAlarm) |=> alarmOutputOne)
		else $error("heater alarm missing on alarm output one");
	a_burn_quiet: assert property ($changed(burnoutAlarm) |-> quietCnt < 4'h6)
		else $error("burnout alarm moved without a closing interval");
	a_sc_quiet: assert property ($changed({shortAlarm, overcurrentAlarm}) |-> quietCnt < 4'h6)
		else $error("short or overcurrent alarm moved without a closing interval");
	a_aw_busy: assert property ((s_axi_awvalid && s_axi_awready) |=> !s_axi_awready [*2])
		else $error("write address accepted while busy");
	a_rd_lat: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_b_done: assert property ((s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write response did not retire");
	a_r_done: assert property ((s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid && s_axi_arready)
		else $error("read response did not retire");
	a_rst_idle: assert property ($rose(nrst) |-> !s_axi_bvalid && !s_axi_rvalid && !rateAlarm && !alarmOutputOne)
		else $error("outputs not idle after reset");
	c_burn: cover property ($rose(|burnoutAlarm));
	c_short: cover property ($rose(|shortAlarm));
	c_over: cover property ($rose(|overcurrentAlarm));
	c_rate: cover property ($rose(rateAlarm));
endmodule // hcam_monitor_props
bind hcam_monitor hcam_monitor_props #(.NCH(NCH)) u_props (.*);
`default_nettype wire

// >>> hcam_ct_model.sv
// hcam_ct_model: two current sensors on the heater power lines
// assumes the bench sets line current for heating on and off; one sample every 4 clocks
`default_nettype none
`timescale 1ns/1ps
module hcam_ct_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic heatingOutput,
	input wire logic [1:0][15:0] onAmps,
	input wire logic [1:0][15:0] offAmps,
	output logic currentValid,
	output logic [1:0][15:0] currentSensorInput
);
	logic [1:0] phase;
	// data scrambled between samples so a stale value is never mistaken for a fresh one
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			phase <= 2'h0;
			currentValid <= 1'b0;
			currentSensorInput <= 32'h0000_0000;
		end else begin
			phase <= phase + 2'h1;
			currentValid <= phase == 2'h3;
			if (phase == 2'h3)
				currentSensorInput <= heatingOutput ? onAmps : offAmps;
			else
				currentSensorInput <= ~currentSensorInput;
		end
	end
endmodule // hcam_ct_model
`default_nettype wire

// >>> hcam_monitor_tb_top.sv
// hcam_monitor_tb_top: register-driven scenarios for the heater current alarm monitor
// assumes hcam_pkg, hcam_ct_model and the bound checker are compiled first
`default_nettype none
`timescale 1ns/1ps
module hcam_monitor_tb_top;
	localparam int SAMP = 20;
	logic sys_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic heatingOutput, currentValid, rateAlarm, alarmOutputOne;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, burnoutAlarm, shortAlarm, overcurrentAlarm;
	logic [15:0] processValue;
	logic [1:0][15:0] currentSensorInput, onAmps, offAmps;
	int n_mismatch, cmp_count, cycles, n;

	// short tick and skip window keep the run under a thousand cycles
	hcam_monitor #(.SAMPLE_CYCLES(SAMP), .SKIP_CYCLES(8), .NCH(2)) dut (.*);
	hcam_ct_model ctm (.*);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// hang guard: far above the fewer than a thousand cycles the sequence needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one write: address and data offered together, bready held until the response
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = hcam_pkg::RESP_OKAY);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(r));
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = hcam_pkg::RESP_OKAY);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk(32'(s_axi_rresp), 32'(r));
	endtask

	// k heating toggles, t cycles apart
	task run(input int t, input int k);
		repeat (k) begin
			heatingOutput <= ~heatingOutput;
			repeat (t) @(posedge sys_clk);
		end
	endtask

	// alarm bits packed as burnout, short, overcurrent, two channels each
	task hchk(input logic [5:0] e);
		chk(32'({burnoutAlarm, shortAlarm, overcurrentAlarm}), 32'(e));
	endtask

	task wait_rate(input logic v);
		n = 0;
		while (rateAlarm !== v && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(rateAlarm), 32'(v));
	endtask

	task results;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		{nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, heatingOutput} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, processValue} = 64'h0;
		s_axi_wstrb = 4'hf;
		onAmps = 32'h0;
		offAmps = 32'h0;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(hcam_pkg::OFF_ALARM_OUTPUT_ONE_TYPE, 32'h2);
		rd(hcam_pkg::OFF_RATE_PERIOD, 32'h4);
		rd(8'h44, 32'h0, hcam_pkg::RESP_SLVERR);
		wr(8'h44, 32'h1, hcam_pkg::RESP_SLVERR);
		wr(hcam_pkg::OFF_RATE_PERIOD, 32'h0);
		rd(hcam_pkg::OFF_RATE_PERIOD, 32'h1);
		wr(hcam_pkg::OFF_RATE_PERIOD, 32'h3e8);
		rd(hcam_pkg::OFF_RATE_PERIOD, 32'h3e7);
		// 2.5 A burnout/short and 20.0 A overcurrent trip points keep a wide margin from the 5.0 A normal load
		for (int i = 0; i < 8; i += 4) begin
			wr(hcam_pkg::OFF_BURNOUT_THR0 + 8'(i), 32'h19);
			wr(hcam_pkg::OFF_SHORT_THR0 + 8'(i), 32'h19);
			wr(hcam_pkg::OFF_OVERCUR_THR0 + 8'(i), 32'hc8);
		end
		wr(hcam_pkg::OFF_ALARM_OUTPUT_ONE_TYPE, 32'h0);
		chk(32'(alarmOutputOne), 32'h0);
		onAmps <= {16'h0000, 16'h0032};
		run(12, 4);
		hchk(6'h20);
		chk(32'(alarmOutputOne), 32'h1);
		onAmps <= {16'h0032, 16'h012c};
		offAmps <= {16'h0000, 16'h0028};
		run(12, 4);
		hchk(6'h05);
		rd(hcam_pkg::OFF_HEAT_MON0, 32'h12c);
		rd(hcam_pkg::OFF_LEAK_MON0, 32'h28);
		run(6, 1);
		onAmps <= 32'h0;
		offAmps <= 32'h0;
		run(6, 4);
		hchk(6'h05);
		onAmps <= {16'h0226, 16'h0227};
		offAmps <= {16'h0000, 16'h0230};
		run(12, 4);
		rd(hcam_pkg::OFF_HEAT_MON0, 32'hffff);
		rd(hcam_pkg::OFF_HEAT_MON1, 32'h226);
		rd(hcam_pkg::OFF_LEAK_MON0, 32'hffff);
		onAmps <= {16'h0032, 16'h0032};
		offAmps <= 32'h0;
		wr(hcam_pkg::OFF_BURNOUT_THR0, 32'h0);
		wr(hcam_pkg::OFF_SHORT_THR0, 32'h0);
		wr(hcam_pkg::OFF_OVERCUR_THR0, 32'h0);
		run(12, 4);
		hchk(6'h05);
		wr(hcam_pkg::OFF_BURNOUT_THR0, 32'h1f4);
		wr(hcam_pkg::OFF_SHORT_THR0, 32'h1f4);
		wr(hcam_pkg::OFF_OVERCUR_THR0, 32'h1f4);
		run(12, 4);
		hchk(6'h10);
		wr(hcam_pkg::OFF_CTRL, 32'h2);
		run(12, 4);
		hchk(6'h00);
		wr(hcam_pkg::OFF_ALARM_OUTPUT_ONE_TYPE, 32'h2);
		wr(hcam_pkg::OFF_SET_POINT, 32'h64);
		wr(hcam_pkg::OFF_ALARM_OUTPUT_ONE_VALUE, 32'ha);
		processValue <= 16'h0073;
		repeat (4) @(posedge sys_clk);
		chk(32'(alarmOutputOne), 32'h1);
		processValue <= 16'h006e;
		repeat (4) @(posedge sys_clk);
		chk(32'(alarmOutputOne), 32'h0);
		wr(hcam_pkg::OFF_ALARM_OUTPUT_ONE_TYPE, 32'hd);
		wr(hcam_pkg::OFF_RATE_PERIOD, 32'h2);
		wr(hcam_pkg::OFF_RATE_VALUE, 32'h5);
		// a fall must not trip a rising-direction setting
		processValue <= 16'h0064;
		repeat (100) @(posedge sys_clk);
		chk(32'(rateAlarm), 32'h0);
		processValue <= 16'h006e;
		wait_rate(1'b1);
		wait_rate(1'b0);
		chk(32'(n), 32'(2 * SAMP));
		wr(hcam_pkg::OFF_RATE_VALUE, 32'h0000fffb);
		processValue <= 16'h0064;
		wait_rate(1'b1);
		repeat (2) @(posedge sys_clk);
		chk(32'(alarmOutputOne), 32'h1);
		wr(hcam_pkg::OFF_CTRL, 32'h3);
		repeat (50) @(posedge sys_clk);
		rd(hcam_pkg::OFF_STATUS, 32'h3);
		wr(hcam_pkg::OFF_CTRL, 32'h7);
		chk(32'(rateAlarm), 32'h0);
		results();
	end
endmodule // hcam_monitor_tb_top
`default_nettype wire
